// ### iex_exc_unit.sv
// Purpose: Instruction exception sequencer: trap, illegal slot, illegal code
// Assumes: Decoder presents one instruction per dec_valid; bus answers with bus_done
// Notes: Stack pushes and vector read are long words; branch target given by pipeline
`timescale 1ns/1ps
`default_nettype none
module iex_exc_unit (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic dec_valid,
   input wire iex_pkg::iex_class_t dec_class,
   input wire logic [7:0] dec_trap_vec,
   input wire logic [31:0] dec_instr_addr,
   input wire logic [31:0] dec_next_addr,
   input wire logic [31:0] branch_target,
   input wire logic [31:0] status_word,
   input wire logic [31:0] stack_pointer,
   input wire logic [31:0] vector_base,
   input wire logic addr_err_req,
   input wire logic cpu_idle,
   input wire logic int_req,
   input wire logic [7:0] int_vec,
   input wire logic bus_done,
   input wire logic [31:0] bus_rdata,
   output logic dec_stall,
   output logic bus_req,
   output logic bus_wr,
   output logic [31:0] bus_addr,
   output logic [31:0] bus_wdata,
   output logic new_pc_valid,
   output logic [31:0] new_pc,
   output logic [31:0] new_stack_pointer,
   output logic int_ack
);
   ////////////////////////////////////////////////////////////////////////////
   // Sequencer states
   ////////////////////////////////////////////////////////////////////////////

   // One state per long-word access; each holds its request until bus_done
   typedef enum logic [1:0] {
      IEX_ST_IDLE,
      IEX_ST_PUSH_STATUS,
      IEX_ST_PUSH_RETURN,
      IEX_ST_VEC_READ
   } iex_state_t;

   iex_state_t state_r;
   iex_state_t state_nxt;
   iex_pkg::iex_kind_t kind_r;
   iex_pkg::iex_kind_t kind_nxt;
   logic [31:0] ret_addr_r;
   logic [31:0] ret_addr_nxt;
   logic [7:0] vec_r;
   logic [7:0] vec_nxt;
   logic [31:0] sp_r;
   logic [31:0] sp_nxt;
   logic [31:0] vb_r;
   logic [31:0] vb_nxt;
   logic in_slot_r;
   logic in_slot_nxt;
   logic after_intdis_r;
   logic after_intdis_nxt;
   logic addr_pend_r;
   logic addr_pend_nxt;
   logic bus_req_nxt;
   logic bus_wr_nxt;
   logic [31:0] bus_addr_nxt;
   logic [31:0] bus_wdata_nxt;
   logic dec_stall_nxt;
   logic new_pc_valid_nxt;
   logic [31:0] new_pc_nxt;
   logic [31:0] new_stack_pointer_nxt;
   logic int_ack_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // Alignment checker on the outgoing access
   ////////////////////////////////////////////////////////////////////////////

   iex_bus_if bus_u ();

   iex_align_chk chk_u (
      .bus(bus_u.chk)
   );

   // Checker sees the registered access exactly as the bus does
   assign bus_u.req = bus_req;
   assign bus_u.wr = bus_wr;
   assign bus_u.stack_acc = bus_req && (state_r == IEX_ST_PUSH_STATUS || state_r == IEX_ST_PUSH_RETURN);
   assign bus_u.vec_acc = bus_req && (state_r == IEX_ST_VEC_READ);
   assign bus_u.addr = bus_addr;

   ////////////////////////////////////////////////////////////////////////////
   // Instruction class decode
   ////////////////////////////////////////////////////////////////////////////

   // Delayed branches open a slot in which nothing may intervene
   wire logic is_delayed_w = (dec_class == iex_pkg::IEX_REG_JUMP) ||
                             (dec_class == iex_pkg::IEX_REG_CALL) ||
                             (dec_class == iex_pkg::IEX_REL_JUMP) ||
                             (dec_class == iex_pkg::IEX_REL_CALL) ||
                             (dec_class == iex_pkg::IEX_SUB_RETURN) ||
                             (dec_class == iex_pkg::IEX_EXC_RETURN);
   // Everything that rewrites the program counter is illegal in a slot
   wire logic is_flow_mod_w = is_delayed_w ||
                              (dec_class == iex_pkg::IEX_COND_TRUE) ||
                              (dec_class == iex_pkg::IEX_COND_FALSE) ||
                              (dec_class == iex_pkg::IEX_TRAP);
   wire logic is_undef_w = (dec_class == iex_pkg::IEX_UNDEFINED);
   wire logic is_trap_w = (dec_class == iex_pkg::IEX_TRAP);
   wire logic is_intdis_w = (dec_class == iex_pkg::IEX_CTRL_SYS_XFER);

   ////////////////////////////////////////////////////////////////////////////
   // Acceptance decisions at decode
   ////////////////////////////////////////////////////////////////////////////

   // Decoder must hold while dec_stall is up; only idle decodes are taken
   wire logic idle_w = (state_r == IEX_ST_IDLE);
   wire logic take_w = dec_valid && idle_w;
   wire logic slot_exc_w = take_w && in_slot_r && (is_flow_mod_w || is_undef_w);
   wire logic gen_exc_w = take_w && !in_slot_r && is_undef_w;
   wire logic trap_exc_w = take_w && !in_slot_r && is_trap_w;
   wire logic instr_exc_w = slot_exc_w || gen_exc_w || trap_exc_w;
   // Address error waits for the slot to pass and the core to drain
   wire logic addr_exc_w = take_w && !in_slot_r && !instr_exc_w && addr_pend_r && cpu_idle;
   // Interrupt refused in a slot and right after a disabling transfer
   wire logic int_exc_w = take_w && !in_slot_r && !after_intdis_r && !instr_exc_w && !addr_exc_w &&
                          int_req;
   wire logic start_w = instr_exc_w || addr_exc_w || int_exc_w;

   ////////////////////////////////////////////////////////////////////////////
   // Bus phase events and addresses
   ////////////////////////////////////////////////////////////////////////////

   wire logic done_w = bus_req && bus_done;
   wire logic status_done_w = done_w && (state_r == IEX_ST_PUSH_STATUS);
   wire logic return_done_w = done_w && (state_r == IEX_ST_PUSH_RETURN);
   wire logic last_w = done_w && (state_r == IEX_ST_VEC_READ);
   // Misaligned pushes still run; the fault is only remembered
   wire logic first_push_w = 1'b0;
   wire logic [31:0] status_addr_w = stack_pointer - iex_pkg::STACK_STEP;
   wire logic [31:0] return_addr_w = sp_r - iex_pkg::STACK_STEP - iex_pkg::STACK_STEP;
   wire logic [31:0] vec_addr_w = vb_r + ({{(iex_pkg::ADDR_W - 8){1'b0}}, vec_r} << iex_pkg::VEC_SHIFT);
   // Faults while stacking for an address error are dropped to avoid a loop
   wire logic access_fault_w = done_w && bus_u.misalign && (kind_r != iex_pkg::IEX_K_ADDR);

   ////////////////////////////////////////////////////////////////////////////
   // Context captured at acceptance
   ////////////////////////////////////////////////////////////////////////////

   assign kind_nxt = !start_w ? kind_r :
                     slot_exc_w ? iex_pkg::IEX_K_SLOT :
                     gen_exc_w ? iex_pkg::IEX_K_GEN :
                     trap_exc_w ? iex_pkg::IEX_K_TRAP :
                     addr_exc_w ? iex_pkg::IEX_K_ADDR : iex_pkg::IEX_K_INT;
   // Slot, general and address errors have fixed vectors; trap and interrupt take theirs from dec_trap_vec and int_vec
   assign vec_nxt = !start_w ? vec_r :
                    slot_exc_w ? iex_pkg::VEC_ILLEGAL_SLOT :
                    gen_exc_w ? iex_pkg::VEC_ILLEGAL_GEN :
                    trap_exc_w ? dec_trap_vec :
                    addr_exc_w ? iex_pkg::VEC_ADDR_ERR : int_vec;
   // Saved return: slot uses branch target, trap the next, others their own
   assign ret_addr_nxt = !start_w ? ret_addr_r :
                         slot_exc_w ? branch_target :
                         trap_exc_w ? dec_next_addr : dec_instr_addr;
   assign sp_nxt = start_w ? stack_pointer : sp_r;
   assign vb_nxt = start_w ? vector_base : vb_r;
   assign in_slot_nxt = take_w ? (is_delayed_w && !start_w) : in_slot_r;
   assign after_intdis_nxt = take_w ? (is_intdis_w && !start_w) : after_intdis_r;
   // Pending fault: a new fault wins over the clear in the same cycle
   assign addr_pend_nxt = addr_err_req || access_fault_w || (addr_pend_r && !addr_exc_w);

   ////////////////////////////////////////////////////////////////////////////
   // Output next values
   ////////////////////////////////////////////////////////////////////////////

   // Status first, then return address, then the vector read
   assign bus_req_nxt = start_w || (bus_req && !last_w);
   assign bus_wr_nxt = start_w || (bus_wr && !return_done_w);
   assign bus_addr_nxt = start_w ? status_addr_w :
                         status_done_w ? return_addr_w :
                         return_done_w ? vec_addr_w : bus_addr;
   assign bus_wdata_nxt = start_w ? status_word :
                          status_done_w ? ret_addr_r : bus_wdata;
   assign dec_stall_nxt = start_w || (dec_stall && !last_w);
   // Handler entered without a delay slot: new target in one strobe
   assign new_pc_valid_nxt = last_w;
   assign new_pc_nxt = last_w ? bus_rdata : new_pc;
   assign new_stack_pointer_nxt = last_w ? return_addr_w : new_stack_pointer;
   assign int_ack_nxt = int_exc_w;

   // Next state of the access sequence
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         IEX_ST_IDLE: if (start_w) state_nxt = IEX_ST_PUSH_STATUS;
         IEX_ST_PUSH_STATUS: if (done_w) state_nxt = IEX_ST_PUSH_RETURN;
         IEX_ST_PUSH_RETURN: if (done_w) state_nxt = IEX_ST_VEC_READ;
         IEX_ST_VEC_READ: if (done_w) state_nxt = IEX_ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   ////////////////////////////////////////////////////////////////////////////

   // Sequencer state and captured context
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_r <= IEX_ST_IDLE;
         kind_r <= iex_pkg::IEX_K_TRAP;
         vec_r <= '0;
         ret_addr_r <= '0;
         sp_r <= '0;
         vb_r <= '0;
      end else begin
         state_r <= state_nxt;
         kind_r <= kind_nxt;
         vec_r <= vec_nxt;
         ret_addr_r <= ret_addr_nxt;
         sp_r <= sp_nxt;
         vb_r <= vb_nxt;
      end
   end

   // Hold-off flags and the pending address error
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         in_slot_r <= 1'b0;
         after_intdis_r <= 1'b0;
         addr_pend_r <= 1'b0;
      end else begin
         in_slot_r <= in_slot_nxt;
         after_intdis_r <= after_intdis_nxt;
         addr_pend_r <= addr_pend_nxt;
      end
   end

   // Bus request outputs, all registered
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         bus_req <= 1'b0;
         bus_wr <= 1'b0;
         bus_addr <= '0;
         bus_wdata <= '0;
      end else begin
         bus_req <= bus_req_nxt;
         bus_wr <= bus_wr_nxt;
         bus_addr <= bus_addr_nxt;
         bus_wdata <= bus_wdata_nxt;
      end
   end

   // Pipeline-facing outputs, all registered
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         dec_stall <= 1'b0;
         new_pc_valid <= 1'b0;
         new_pc <= '0;
         new_stack_pointer <= '0;
         int_ack <= 1'b0;
      end else begin
         dec_stall <= dec_stall_nxt;
         new_pc_valid <= new_pc_valid_nxt;
         new_pc <= new_pc_nxt;
         new_stack_pointer <= new_stack_pointer_nxt;
         int_ack <= int_ack_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   ////////////////////////////////////////////////////////////////////////////

   property p_slot_refuses_int;
      @(posedge ref_clk) disable iff (sys_rst)
      take_w && in_slot_r && int_req |=> !int_ack;
   endproperty
   a_slot_refuses_int: assert property (p_slot_refuses_int) else $error("interrupt taken in a delay slot");

   property p_intdis_refuses_int;
      @(posedge ref_clk) disable iff (sys_rst)
      take_w && after_intdis_r && int_req |=> !int_ack;
   endproperty
   a_intdis_refuses_int: assert property (p_intdis_refuses_int) else $error("interrupt after disabling");

   property p_slot_context;
      @(posedge ref_clk) disable iff (sys_rst)
      slot_exc_w |=> vec_r == iex_pkg::VEC_ILLEGAL_SLOT && ret_addr_r == $past(branch_target);
   endproperty
   a_slot_context: assert property (p_slot_context) else $error("slot exception context wrong");

   property p_gen_context;
      @(posedge ref_clk) disable iff (sys_rst)
      gen_exc_w |=> vec_r == iex_pkg::VEC_ILLEGAL_GEN && ret_addr_r == $past(dec_instr_addr);
   endproperty
   a_gen_context: assert property (p_gen_context) else $error("general illegal context wrong");

   property p_trap_context;
      @(posedge ref_clk) disable iff (sys_rst)
      trap_exc_w |=> vec_r == $past(dec_trap_vec) && ret_addr_r == $past(dec_next_addr);
   endproperty
   a_trap_context: assert property (p_trap_context) else $error("trap context wrong");

   property p_return_push_step;
      @(posedge ref_clk) disable iff (sys_rst)
      status_done_w |=> bus_req && bus_wr && bus_addr == $past(bus_addr) - iex_pkg::STACK_STEP;
   endproperty
   a_return_push_step: assert property (p_return_push_step) else $error("second push not one step down");

   property p_fault_pending;
      @(posedge ref_clk) disable iff (sys_rst)
      done_w && bus_u.misalign && kind_r != iex_pkg::IEX_K_ADDR |=> addr_pend_r;
   endproperty
   a_fault_pending: assert property (p_fault_pending) else $error("stacking fault not kept pending");

   property p_fault_ignored;
      @(posedge ref_clk) disable iff (sys_rst)
      done_w && bus_u.misalign && kind_r == iex_pkg::IEX_K_ADDR && !addr_pend_r && !addr_err_req |=> !addr_pend_r;
   endproperty
   a_fault_ignored: assert property (p_fault_ignored) else $error("fault during address error kept");

   // Main scenarios reached
   c_trap_taken: cover property (@(posedge ref_clk) disable iff (sys_rst) trap_exc_w);
   c_slot_taken: cover property (@(posedge ref_clk) disable iff (sys_rst) slot_exc_w);
   c_addr_taken: cover property (@(posedge ref_clk) disable iff (sys_rst) addr_exc_w);
   c_int_taken: cover property (@(posedge ref_clk) disable iff (sys_rst) int_exc_w);
endmodule : iex_exc_unit
`default_nettype wire

// ### iex_pkg.sv
// Purpose: Shared constants and types for the instruction exception unit
// Assumes: 32-bit addresses, long-word stack and vector accesses
// Notes: Vector numbers other than the trap's and the interrupt's are fixed here
package iex_pkg;
   localparam int unsigned ADDR_W = 32;
   localparam logic [7:0] VEC_ILLEGAL_GEN = 8'h04;
   localparam logic [7:0] VEC_ILLEGAL_SLOT = 8'h06;
   localparam logic [7:0] VEC_ADDR_ERR = 8'h09;
   localparam logic [31:0] STACK_STEP = 32'h0000_0004;
   localparam logic [1:0] ALIGN_ZERO = 2'h0;
   localparam int unsigned VEC_SHIFT = 2;

   // Decoded instruction classes
   typedef enum logic [3:0] {
      IEX_OTHER, IEX_REG_JUMP, IEX_REG_CALL, IEX_REL_JUMP, IEX_REL_CALL,
      IEX_SUB_RETURN, IEX_EXC_RETURN, IEX_COND_TRUE, IEX_COND_FALSE,
      IEX_TRAP, IEX_CTRL_SYS_XFER, IEX_UNDEFINED
   } iex_class_t;

   // Exception kinds being processed
   typedef enum logic [2:0] {
      IEX_K_TRAP, IEX_K_SLOT, IEX_K_GEN, IEX_K_ADDR, IEX_K_INT
   } iex_kind_t;
endpackage : iex_pkg

// ### iex_bus_if.sv
// Purpose: Bus request bundle between sequencer and alignment checker
// Assumes: One outstanding long-word access at a time
// Notes: Checker only observes, never stalls
`timescale 1ns/1ps
`default_nettype none
interface iex_bus_if;
   logic req;
   logic wr;
   logic stack_acc;
   logic vec_acc;
   logic [31:0] addr;
   logic misalign;
   modport seq (output req, output wr, output stack_acc, output vec_acc, output addr, input misalign);
   modport chk (input req, input wr, input stack_acc, input vec_acc, input addr, output misalign);
endinterface : iex_bus_if
`default_nettype wire

// ### iex_align_chk.sv
// Purpose: Flags stack and vector accesses that are not long-word aligned
// Assumes: Address bits 1:0 give the long-word alignment
// Notes: Purely combinational; the access itself still runs
`timescale 1ns/1ps
`default_nettype none
module iex_align_chk (
   iex_bus_if.chk bus
);
   // Misaligned stack push or vector read
   wire low_bits_set = (bus.addr[1:0] != iex_pkg::ALIGN_ZERO);
   assign bus.misalign = bus.req && (bus.stack_acc || bus.vec_acc) && low_bits_set;
endmodule : iex_align_chk
`default_nettype wire

// ### iex_bus_model.sv
// Purpose: Bus responder for stack pushes and vector reads
// Assumes: Handler address read back is the inverted request address
// Notes: One wait cycle per access; read data is the plain request address outside done
`timescale 1ns/1ps
`default_nettype none
module iex_bus_model (
   input wire logic ref_clk,
   input wire logic bus_req,
   input wire logic [31:0] bus_addr,
   output logic bus_done,
   output logic [31:0] bus_rdata
);
   // Acknowledge after a wait; stale data never lingers
   always_ff @(posedge ref_clk) begin
      bus_done <= bus_req && !bus_done;
      bus_rdata <= (bus_req && !bus_done) ? ~bus_addr : bus_addr;
   end
endmodule : iex_bus_model
`default_nettype wire

// ### iex_exc_unit_bench.sv
// Purpose: Self-checking bench for the exception sequencer
// Assumes: Vectored target is the inverted vector table address
// Notes: Trap with random vector, then general undefined code
`timescale 1ns/1ps
`default_nettype none
module iex_exc_unit_bench;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic dec_valid = 1'b0;
   logic addr_err_req = 1'b0;
   logic cpu_idle = 1'b1;
   logic int_req = 1'b0;
   logic bus_done, dec_stall, bus_req, bus_wr, new_pc_valid, int_ack;
   logic [7:0] dec_trap_vec = 8'h00;
   logic [7:0] int_vec = 8'h00;
   logic [7:0] v;
   logic [31:0] dec_instr_addr = 32'h0000_0000;
   logic [31:0] dec_next_addr = 32'h0000_0000;
   logic [31:0] branch_target = 32'h0000_0000;
   logic [31:0] status_word = 32'h0000_0000;
   logic [31:0] stack_pointer = 32'h0000_2000;
   logic [31:0] vector_base = 32'h0000_1000;
   logic [31:0] bus_rdata, bus_addr, bus_wdata, new_pc, new_stack_pointer;
   logic [31:0] exp_q[$];
   logic [31:0] sp_q[$];
   logic [31:0] wd_q[$];
   logic [31:0] wa_q[$];
   iex_pkg::iex_class_t dec_class = iex_pkg::IEX_OTHER;
   int n_errors = 0;
   int checks = 0;
   int n_acks = 0;
   always #50 ref_clk = ~ref_clk;
   iex_bus_model bm_u (.ref_clk(ref_clk), .bus_req(bus_req), .bus_addr(bus_addr), .bus_done(bus_done),
                       .bus_rdata(bus_rdata));
   iex_exc_unit dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .dec_valid(dec_valid), .dec_class(dec_class),
                       .dec_trap_vec(dec_trap_vec), .dec_instr_addr(dec_instr_addr), .dec_next_addr(dec_next_addr),
                       .branch_target(branch_target), .status_word(status_word), .stack_pointer(stack_pointer),
                       .vector_base(vector_base), .addr_err_req(addr_err_req), .cpu_idle(cpu_idle),
                       .int_req(int_req), .int_vec(int_vec), .bus_done(bus_done), .bus_rdata(bus_rdata),
                       .dec_stall(dec_stall), .bus_req(bus_req), .bus_wr(bus_wr), .bus_addr(bus_addr),
                       .bus_wdata(bus_wdata), .new_pc_valid(new_pc_valid), .new_pc(new_pc),
                       .new_stack_pointer(new_stack_pointer), .int_ack(int_ack));
   // Drive one decode; sel picks the saved return: 0 next, 1 own, 2 branch target
   task automatic issue(input iex_pkg::iex_class_t c, input logic [7:0] tv, input logic intr, input logic exc,
                        input logic [7:0] n, input int sel);
      logic [31:0] sw;
      logic [31:0] ia;
      logic [31:0] na;
      logic [31:0] bt;
      sw = $urandom;
      ia = $urandom;
      na = ia + 32'h0000_0002;
      bt = $urandom;
      @(posedge ref_clk);
      dec_class <= c;
      dec_trap_vec <= tv;
      int_vec <= tv;
      int_req <= intr;
      dec_valid <= 1'b1;
      status_word <= sw;
      dec_instr_addr <= ia;
      dec_next_addr <= na;
      branch_target <= bt;
      if (exc) begin
         exp_q.push_back(~(vector_base + {22'h0, n, 2'h0}));
         sp_q.push_back(stack_pointer - 32'h0000_0008);
         wa_q.push_back(stack_pointer - 32'h0000_0004);
         wa_q.push_back(stack_pointer - 32'h0000_0008);
         wd_q.push_back(sw);
         wd_q.push_back(sel == 0 ? na : (sel == 1 ? ia : bt));
      end
      @(posedge ref_clk);
      dec_valid <= 1'b0;
      int_req <= 1'b0;
      repeat (40) @(posedge ref_clk);
      $display("test class %0d done", c);
   endtask : issue
   task automatic check_pc(input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] new_pc exp %h got %h", exp, got);
      end
   endtask : check_pc
   task automatic check_sp(input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] new_stack_pointer exp %h got %h", exp, got);
      end
   endtask : check_sp
   task automatic check_push(input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] bus_wdata exp %h got %h", exp, got);
      end
   endtask : check_push
   task automatic check_addr(input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] bus_addr exp %h got %h", exp, got);
      end
   endtask : check_addr
   task automatic check_cnt(input int exp, input int got);
      checks++;
      if (got != exp) begin
         n_errors++;
         $display("[ERR] int_ack count exp %0d got %0d", exp, got);
      end
   endtask : check_cnt
   task automatic test_done;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done
   // Oldest notes are compared as each result appears; a missing note is unknown
   always @(posedge ref_clk) begin
      if (new_pc_valid === 1'b1) begin
         check_pc(exp_q.size() ? exp_q.pop_front() : 32'hXXXX_XXXX, new_pc);
         check_sp(sp_q.size() ? sp_q.pop_front() : 32'hXXXX_XXXX, new_stack_pointer);
      end
      if (bus_req === 1'b1 && bus_wr === 1'b1 && bus_done === 1'b1) begin
         check_push(wd_q.size() ? wd_q.pop_front() : 32'hXXXX_XXXX, bus_wdata);
         check_addr(wa_q.size() ? wa_q.pop_front() : 32'hXXXX_XXXX, bus_addr);
      end
      if (int_ack === 1'b1) n_acks++;
   end
   initial begin
      void'($urandom(32'h6e20));
      v = $urandom;
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      issue(iex_pkg::IEX_TRAP, v, 1'b0, 1'b1, v, 0);
      issue(iex_pkg::IEX_UNDEFINED, v, 1'b0, 1'b1, iex_pkg::VEC_ILLEGAL_GEN, 1);
      issue(iex_pkg::IEX_REG_JUMP, v, 1'b0, 1'b0, v, 0);
      issue(iex_pkg::IEX_TRAP, v, 1'b1, 1'b1, iex_pkg::VEC_ILLEGAL_SLOT, 2);
      issue(iex_pkg::IEX_CTRL_SYS_XFER, v, 1'b0, 1'b0, v, 0);
      issue(iex_pkg::IEX_OTHER, v, 1'b1, 1'b0, v, 0);
      issue(iex_pkg::IEX_OTHER, v, 1'b1, 1'b1, v, 1);
      stack_pointer <= 32'h0000_2002;
      issue(iex_pkg::IEX_TRAP, v, 1'b0, 1'b1, v, 0);
      issue(iex_pkg::IEX_OTHER, v, 1'b0, 1'b1, iex_pkg::VEC_ADDR_ERR, 1);
      issue(iex_pkg::IEX_OTHER, v, 1'b0, 1'b0, v, 0);
      check_cnt(1, n_acks);
      n_errors += exp_q.size() + sp_q.size() + wd_q.size() + wa_q.size();
      test_done();
   end
   // Ten tests of 42 cycles each; over twice that span is allowed
   initial begin
      #100000;
      n_errors++;
      test_done();
   end
endmodule : iex_exc_unit_bench
`default_nettype wire
